/* include/ext_prio_pkg.sv */
// Purpose: Shared constants for the extended interrupt priority select block
// Assumes: AHB-Lite slave with 32-bit data, single word transfers only
// Notes: Source index order is conversion-done, then external 4 to 7
package ext_prio_pkg;
    // Register byte offsets
    localparam logic [7:0] PRIO_SEL_OFS = 8'h00; // Priority select register
    localparam logic [7:0] ARB_STAT_OFS = 8'h04; // Arbitration status register
    localparam int ADDR_W = 8; // Decoded address bits

    // Priority select bit positions
    localparam int CONV_DONE_BIT = 1; // Conversion-done level bit
    localparam int EXT4_BIT = 2; // External interrupt 4 level bit
    localparam int EXT5_BIT = 3; // External interrupt 5 level bit
    localparam int EXT6_BIT = 4; // External interrupt 6 level bit
    localparam int EXT7_BIT = 5; // External interrupt 7 level bit
    localparam logic [7:0] PRIO_SEL_RST = 8'h00; // All sources low after reset

    // Number of sources handled here
    localparam int NUM_SRC = 5;
    localparam int ID_W = 3;

    // Status register field positions
    localparam int STAT_PEND_LSB = 0; // Pending request bits 4:0
    localparam int STAT_ID_LSB = 8; // Granted source id bits 10:8
    localparam int STAT_HIGH_BIT = 12; // Granted source is high level
    localparam int STAT_VALID_BIT = 13; // A grant is present

    // AHB transfer type codes
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;
    localparam logic HRESP_OKAY = 1'h0;
endpackage

/* rtl/ext_prio_sel.sv */
// Purpose: Per-source priority level select and level arbitration
// Assumes: Request inputs synchronous to ref_clk, AHB-Lite master on the bus
// Notes: Zero wait states; unmapped addresses read zero and ignore writes
// Overview of operation
// - Bit 5 sets external interrupt 7 level
// - Bit 4 sets external interrupt 6 level
// - Bit 3 sets external interrupt 5 level
// - Bit 2 sets external interrupt 4 level
// - Bit 1 sets conversion-done interrupt level
`timescale 1ns/1ps
module ext_prio_sel (
    input wire logic ref_clk, // System clock, 100 MHz
    input wire logic rstn, // Asynchronous reset, active low
    input wire logic hsel, // Slave select
    input wire logic [31:0] haddr, // Byte address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write when high
    input wire logic [2:0] hsize, // Transfer size
    input wire logic [31:0] hwdata, // Write data
    input wire logic hready, // Bus ready
    output logic hreadyout, // Slave ready
    output logic [31:0] hrdata, // Read data
    output logic hresp, // Response, always OKAY
    input wire logic [4:0] reqPending, // Pending requests, index order as package
    output logic ext_irq7_level_sel, // External 7 high level
    output logic ext_irq6_level_sel, // External 6 high level
    output logic ext_irq5_level_sel, // External 5 high level
    output logic ext_irq4_level_sel, // External 4 high level
    output logic conv_done_level_sel, // Conversion-done high level
    output logic grantValid, // A request is granted
    output logic [2:0] grantId, // Granted source index
    output logic grantHigh // Granted source is high level
);
    // Reset synchroniser
    logic rstMeta_ff; // First stage
    logic rstSyncN_ff; // Released reset copy

    // Bus state
    logic wrPend_ff; // Data-phase write pending
    logic [ext_prio_pkg::ADDR_W-1:0] wrAddr_ff; // Captured write address
    logic [31:0] rdData_ff; // Registered read data
    logic readyOut_ff; // Ready output flop
    logic respCode_ff; // Response flop, held at OKAY

    // Priority select register
    logic [7:0] prioSel_ff; // Level bits
    logic [7:0] nxt_prioSel; // Next level bits

    // Arbitration result
    logic grantValid_ff; // Grant present
    logic [ext_prio_pkg::ID_W-1:0] grantId_ff; // Granted index
    logic grantHigh_ff; // Granted level

    // Release reset through two flops
    // Assert acts at once; release waits two edges to avoid a metastable exit
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rstMeta_ff <= 1'h0;
            rstSyncN_ff <= 1'h0;
        end else begin
            rstMeta_ff <= 1'h1;
            rstSyncN_ff <= rstMeta_ff;
        end
    end

    // Address phase decode
    // Transfer size is ignored; every transfer is taken as one whole word
    wire trValid = hsel && hready && (htrans == ext_prio_pkg::HTRANS_NONSEQ || htrans == ext_prio_pkg::HTRANS_SEQ);
    wire [ext_prio_pkg::ADDR_W-1:0] aphAddr = haddr[ext_prio_pkg::ADDR_W-1:0];
    wire aphWrite = trValid && hwrite;
    wire aphRead = trValid && !hwrite;
    wire wrPrio = wrPend_ff && (wrAddr_ff == ext_prio_pkg::PRIO_SEL_OFS);

    // Level bit vector in source index order
    wire [ext_prio_pkg::NUM_SRC-1:0] srcLevel = {
        prioSel_ff[ext_prio_pkg::EXT7_BIT],
        prioSel_ff[ext_prio_pkg::EXT6_BIT],
        prioSel_ff[ext_prio_pkg::EXT5_BIT],
        prioSel_ff[ext_prio_pkg::EXT4_BIT],
        prioSel_ff[ext_prio_pkg::CONV_DONE_BIT]};

    // Only the five level bits are writable; others read zero
    // Built from the bit positions so a moved field cannot leave a stale mask
    wire [7:0] prioWrMask = (8'h01 << ext_prio_pkg::EXT7_BIT)
        | (8'h01 << ext_prio_pkg::EXT6_BIT)
        | (8'h01 << ext_prio_pkg::EXT5_BIT)
        | (8'h01 << ext_prio_pkg::EXT4_BIT)
        | (8'h01 << ext_prio_pkg::CONV_DONE_BIT);
    assign nxt_prioSel = wrPrio ? (hwdata[7:0] & prioWrMask) : prioSel_ff;

    // Requests split by level
    wire [ext_prio_pkg::NUM_SRC-1:0] highReq = reqPending & srcLevel;
    wire [ext_prio_pkg::NUM_SRC-1:0] lowReq = reqPending & ~srcLevel;
    wire anyHigh = |highReq;
    wire [ext_prio_pkg::NUM_SRC-1:0] pickSet = anyHigh ? highReq : lowReq;

    // Lowest index wins within a level
    // Walks downward so the lowest pending index writes last
    logic [ext_prio_pkg::ID_W-1:0] nxt_grantId;
    always_comb begin
        nxt_grantId = '0;
        for (int i = ext_prio_pkg::NUM_SRC - 1; i >= 0; i--) begin
            if (pickSet[i]) begin
                nxt_grantId = ext_prio_pkg::ID_W'(i);
            end
        end
    end

    // Status word
    wire [31:0] statWord = (32'(reqPending) << ext_prio_pkg::STAT_PEND_LSB)
        | (32'(grantId_ff) << ext_prio_pkg::STAT_ID_LSB)
        | (32'(grantHigh_ff) << ext_prio_pkg::STAT_HIGH_BIT)
        | (32'(grantValid_ff) << ext_prio_pkg::STAT_VALID_BIT);

    // Read data select, unmapped reads zero
    // Sampled in the address phase, so a pipelined read after a write sees the old bits
    wire [31:0] nxt_rdData = !aphRead ? 32'h0
        : (aphAddr == ext_prio_pkg::PRIO_SEL_OFS) ? {24'h0, prioSel_ff}
        : (aphAddr == ext_prio_pkg::ARB_STAT_OFS) ? statWord
        : 32'h0;

    // Bus phase tracking
    always_ff @(posedge ref_clk or negedge rstSyncN_ff) begin
        if (!rstSyncN_ff) begin
            wrPend_ff <= 1'h0;
            wrAddr_ff <= '0;
            rdData_ff <= 32'h0;
            readyOut_ff <= 1'h0;
            respCode_ff <= ext_prio_pkg::HRESP_OKAY;
        end else begin
            wrPend_ff <= aphWrite;
            wrAddr_ff <= aphAddr;
            rdData_ff <= nxt_rdData;
            readyOut_ff <= 1'h1;
            respCode_ff <= ext_prio_pkg::HRESP_OKAY;
        end
    end

    // Priority select register
    always_ff @(posedge ref_clk or negedge rstSyncN_ff) begin
        if (!rstSyncN_ff) begin
            prioSel_ff <= ext_prio_pkg::PRIO_SEL_RST;
        end else begin
            prioSel_ff <= nxt_prioSel;
        end
    end

    // Arbitration result register
    // One cycle late so the grant pins come straight from flops
    always_ff @(posedge ref_clk or negedge rstSyncN_ff) begin
        if (!rstSyncN_ff) begin
            grantValid_ff <= 1'h0;
            grantId_ff <= '0;
            grantHigh_ff <= 1'h0;
        end else begin
            grantValid_ff <= |reqPending;
            grantId_ff <= nxt_grantId;
            grantHigh_ff <= anyHigh;
        end
    end

    // Outputs from flops
    assign hreadyout = readyOut_ff;
    assign hrdata = rdData_ff;
    assign hresp = respCode_ff;
    assign ext_irq7_level_sel = prioSel_ff[ext_prio_pkg::EXT7_BIT];
    assign ext_irq6_level_sel = prioSel_ff[ext_prio_pkg::EXT6_BIT];
    assign ext_irq5_level_sel = prioSel_ff[ext_prio_pkg::EXT5_BIT];
    assign ext_irq4_level_sel = prioSel_ff[ext_prio_pkg::EXT4_BIT];
    assign conv_done_level_sel = prioSel_ff[ext_prio_pkg::CONV_DONE_BIT];
    assign grantValid = grantValid_ff;
    assign grantId = grantId_ff;
    assign grantHigh = grantHigh_ff;

    // Checks
    // All checks sleep until the released reset copy is high
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstSyncN_ff);

    a_irq7_level_write: assert property (wrPrio |=> ext_irq7_level_sel == $past(hwdata[5]))
        else $error("External 7 level not taken from write");
    a_irq6_level_write: assert property (wrPrio |=> ext_irq6_level_sel == $past(hwdata[4]))
        else $error("External 6 level not taken from write");
    a_irq5_level_write: assert property (wrPrio |=> ext_irq5_level_sel == $past(hwdata[3]))
        else $error("External 5 level not taken from write");
    a_irq4_level_write: assert property (wrPrio |=> ext_irq4_level_sel == $past(hwdata[2]))
        else $error("External 4 level not taken from write");
    a_conv_level_write: assert property (wrPrio |=> conv_done_level_sel == $past(hwdata[1]))
        else $error("Conversion-done level not taken from write");
    a_level_hold: assert property (!wrPrio |=> $stable(prioSel_ff))
        else $error("Level bits changed without a write");
    // Judged on what was sampled at the grant edge; a level write may land in that cycle
    a_high_wins: assert property ((|(reqPending & srcLevel)) |=> grantValid && grantHigh
        && (($past(reqPending & srcLevel) >> grantId) & 5'h01) == 5'h01
        && ($past(reqPending & srcLevel) & ((5'h01 << grantId) - 5'h01)) == 5'h00)
        else $error("High request not granted ahead of low");
    // Low grant goes to the lowest pending index when nothing high waits
    a_low_only: assert property ((|reqPending) && !(|(reqPending & srcLevel)) |=> grantValid
        && !grantHigh
        && (($past(reqPending) >> grantId) & 5'h01) == 5'h01
        && ($past(reqPending) & ((5'h01 << grantId) - 5'h01)) == 5'h00)
        else $error("Low grant wrong when no high pending");
    // Nothing pending leaves the grant flags clear
    a_idle_no_grant: assert property (!(|reqPending) |=> !grantValid && !grantHigh)
        else $error("Grant shown with no request pending");
    // Reserved places of the select register never hold a one
    a_reserved_zero: assert property ((prioSel_ff & ~prioWrMask) == 8'h00)
        else $error("Reserved select bit set");
    // A select read returns the level bits held at the address phase
    a_select_readback: assert property (aphRead && aphAddr == ext_prio_pkg::PRIO_SEL_OFS
        |=> hrdata == {24'h00, $past(prioSel_ff)})
        else $error("Select readback differs from level bits");
    // Unmapped reads return zero
    a_unmapped_read: assert property (aphRead && aphAddr != ext_prio_pkg::PRIO_SEL_OFS
        && aphAddr != ext_prio_pkg::ARB_STAT_OFS |=> hrdata == 32'h0)
        else $error("Unmapped read returned nonzero data");
    // Status read carries the grant flag of the address phase
    a_status_valid: assert property (aphRead && aphAddr == ext_prio_pkg::ARB_STAT_OFS
        |=> hrdata[ext_prio_pkg::STAT_VALID_BIT] == $past(grantValid_ff))
        else $error("Status grant flag differs from grant");
    // Read data stays zero outside a read data phase
    a_idle_read_zero: assert property (!aphRead |=> hrdata == 32'h0)
        else $error("Read data shown without a read");
endmodule // ext_prio_sel

/* verif/testbench.sv */
// Purpose: Self-checking bench for the priority select and arbitration block
// Assumes: Zero-wait AHB-Lite slave, hready fed back from hreadyout
// Notes: Status register read at offset 0x04 after each grant check
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checkCount++; if ((got) !== (ex)) begin fails++; \
    $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module testbench;
    logic ref_clk; // System clock
    logic rstn; // Reset, active low
    logic hsel; // Slave select
    logic [31:0] haddr; // Byte address
    logic [1:0] htrans; // Transfer type
    logic hwrite; // Write strobe
    logic [31:0] hwdata; // Write data
    logic hreadyout; // Slave ready
    logic [31:0] hrdata; // Read data
    logic hresp; // Response code
    logic [4:0] reqPending; // Pending requests
    wire [7:0] lvl; // Level outputs packed at their bit places
    logic grantValid, grantHigh; // Grant flags
    logic [2:0] grantId; // Granted index
    logic [31:0] rd; // Last read word
    int fails = 0; // Mismatch count
    int checkCount = 0; // Comparison count
    ext_prio_sel dut_u (.ref_clk(ref_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .reqPending(reqPending), .ext_irq7_level_sel(lvl[5]),
        .ext_irq6_level_sel(lvl[4]), .ext_irq5_level_sel(lvl[3]), .ext_irq4_level_sel(lvl[2]),
        .conv_done_level_sel(lvl[1]), .grantValid(grantValid), .grantId(grantId), .grantHigh(grantHigh));
    assign {lvl[7:6], lvl[0]} = 3'h0; // Unused places
    // Clock generation
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // Verdict and end of run
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", checkCount, fails);
        if (fails == 0 && checkCount > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Wait for hready high at a rising edge, bounded
    task automatic waitReady();
        int n;
        n = 0;
        do begin @(posedge ref_clk); n++; end while (hreadyout !== 1'b1 && n < 20);
        if (hreadyout !== 1'b1) begin fails++; $display("MISMATCH hready wait expected 1 seen timeout"); conclude(); end
    endtask
    // One single-word transfer: address phase, then data phase
    task automatic xfer(input logic wr, input logic [7:0] ofs, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h0, ofs};
        htrans <= ext_prio_pkg::HTRANS_NONSEQ;
        hwrite <= wr;
        waitReady();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        waitReady();
        rd = hrdata;
    endtask
    // Write a level word, read it back, check pins and readback
    task automatic setLevels(input logic [31:0] wd, input logic [7:0] ex);
        xfer(1'b1, ext_prio_pkg::PRIO_SEL_OFS, wd);
        xfer(1'b0, ext_prio_pkg::PRIO_SEL_OFS, 32'h0);
        `CHK("select readback", {24'h0, ex}, rd)
        `CHK("level pins", ex, lvl)
        `CHK("response", ext_prio_pkg::HRESP_OKAY, hresp)
    endtask
    // Reset values, then every level bit alone, then reserved and unmapped places
    task automatic testLevels();
        xfer(1'b0, ext_prio_pkg::PRIO_SEL_OFS, 32'h0);
        `CHK("select after reset", 32'h0, rd)
        for (int i = 1; i <= 5; i++) setLevels(32'h1 << i, 8'h1 << i);
        setLevels(32'hffffffff, 8'h3e);
        xfer(1'b1, 8'h08, 32'h0);
        xfer(1'b0, 8'h08, 32'h0);
        `CHK("unmapped read", 32'h0, rd)
        `CHK("levels after unmapped write", 8'h3e, lvl)
        $display("test levels done");
    endtask
    // Apply requests, check grant pins and status word
    task automatic arb(input logic [31:0] sel, input logic [4:0] req, input logic [2:0] id, input logic hi);
        setLevels(sel, sel[7:0]);
        reqPending <= req;
        @(posedge ref_clk);
        @(posedge ref_clk);
        #1 `CHK("grant", {|req, id, hi}, {grantValid, grantId, grantHigh})
        @(posedge ref_clk);
        xfer(1'b0, ext_prio_pkg::ARB_STAT_OFS, 32'h0);
        `CHK("status", {18'h0, |req, hi, 1'b0, id, 3'h0, req}, rd)
    endtask
    // High pending beats low pending; lowest index within a level
    task automatic testArb();
        arb(32'h08, 5'b01101, 3'h2, 1'b1);
        arb(32'h00, 5'b10110, 3'h1, 1'b0);
        arb(32'h20, 5'b11111, 3'h4, 1'b1);
        arb(32'h02, 5'b10101, 3'h0, 1'b1);
        arb(32'h14, 5'b11001, 3'h3, 1'b1);
        arb(32'h14, 5'b01010, 3'h1, 1'b1);
        arb(32'h14, 5'b10101, 3'h0, 1'b0);
        arb(32'h00, 5'b00000, 3'h0, 1'b0);
        $display("test arbitration done");
    endtask
    // Main sequence
    initial begin
        rstn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        reqPending = 5'h0;
        repeat (4) @(posedge ref_clk);
        rstn <= 1'b0 | 1'b1;
        repeat (4) @(posedge ref_clk);
        testLevels();
        testArb();
        conclude();
    end
endmodule // testbench
